//--- verilog/bridge_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.svh"

// ==============================================================
// word fifo between the user write port and the bus master
module word_fifo #(
    parameter int WIDTH = `AD_W,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_ptr_type;

    fifo_ptr_type     q;
    fifo_ptr_type     d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("fifo depth must be a power of two, at least 2");
    end

    assign o_in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign o_out_valid = q.cnt != '0;
    assign o_out_data  = mem_q[q.rd];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.wr = q.wr + 1'h1;
        end
        if (pop) begin
            d.rd = q.rd + 1'h1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[q.wr] <= i_in_data;
        end
    end
endmodule // word_fifo

// ==============================================================
// bridge end of the link
// Operation
// - target ready held until its data phase completes
// - sustained lines driven high one cycle, then floated
// - no device select within 5 cycles: master abort
// - stop from target ends the initiator's transaction
// - type 0 config claimed only with config select
// - received data parity error asserts parity error
// - parity, secondary error, aborts raise system error
// - discarded requests and master timeout raise system error
// - request stays deasserted at least 2 cycles
// - bridge starts transactions only while granted
// - idle granted bus parked with valid levels
// - reset floats all bus outputs asynchronously
// - address with frame; data with ready signals
// - word moves when both ready signals asserted
// - command in address phase, byte enables after
// - idle bus with own grant driven valid
// - even parity presented one clock later
module bridge_device
    import bridge_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset_n,
    pci_link_if.bridge_end               link,
    input  wire logic                    i_wr_valid,
    output logic                         o_wr_ready,
    input  wire logic [`AD_W-1:0]        i_wr_data,
    input  wire logic [`AD_W-1:0]        i_wr_addr,
    input  wire logic                    i_sec_serr_n,
    input  wire logic [`ERR_EVENTS-1:0]  i_discard_events,
    output logic      [`AD_W-1:0]        o_cfg_value,
    output logic                         o_master_abort,
    output logic                         o_target_abort,
    output logic                         o_parity_error
);
    bridge_regs_type  q;
    bridge_regs_type  d;
    logic             fifo_valid;
    logic             fifo_pop;
    logic [`AD_W-1:0] fifo_data;
    logic             bus_idle;
    logic             addr_phase;
    logic             claim;
    logic             peer_perr;
    logic             par_bad;
    logic             end_txn;

    word_fifo #(
        .WIDTH (`AD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_wr_valid),
        .o_in_ready  (o_wr_ready),
        .i_in_data   (i_wr_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_data)
    );

    // ==============================================================
    // bus decode
    assign bus_idle   = link.ctl[`CTL_FRAME] & link.ctl[`CTL_IRDY];
    assign addr_phase = ~link.ctl[`CTL_FRAME] & q.frame_prev & (q.st == B_IDLE);
    assign claim      = addr_phase & link.idsel & (link.ad[1:0] == `CFG_TYPE0)
                        & ((link.cbe == `CMD_CFG_READ) | (link.cbe == `CMD_CFG_WRITE));
    assign peer_perr  = ~link.ctl[`CTL_PERR] & ~q.own[`CTL_PERR] & ~q.rel[`CTL_PERR];
    assign par_bad    = even_parity(q.chk_ad, q.chk_cbe) ^ link.par;

    // ==============================================================
    // next state
    always_comb begin
        d            = q;
        fifo_pop     = 1'h0;
        end_txn      = 1'h0;
        d.live       = 1'h1;
        d.frame_prev = link.ctl[`CTL_FRAME];
        d.par        = even_parity(q.ad, q.cbe);
        d.par_oe     = q.ad_oe;
        d.chk_data   = 1'h0;
        d.chk_addr   = 1'h0;
        d.mabort     = 1'h0;
        d.tabort     = 1'h0;
        if (q.gap != '0) begin
            d.gap = q.gap - 2'h1;
        end
        unique case (q.st)
            B_IDLE: begin
                d.own   = '0;
                d.ad_oe = 1'h0;
                if (addr_phase) begin
                    d.chk_addr = 1'h1;
                    d.chk_ad   = link.ad;
                    d.chk_cbe  = link.cbe;
                end
                if (claim) begin
                    d.st                = B_TDATA;
                    d.own[`CTL_DEVSEL]  = 1'h1;
                    d.own[`CTL_TRDY]    = 1'h1;
                    d.tgt_write         = link.cbe == `CMD_CFG_WRITE;
                    d.ad                = q.cfg;
                    d.cbe               = `BE_ALL_N;
                    d.ad_oe             = link.cbe == `CMD_CFG_READ;
                end else if (q.req & ~link.gnt_n & bus_idle & fifo_valid) begin
                    d.st             = B_ADDR;
                    d.own[`CTL_FRAME] = 1'h1;
                    d.ad             = i_wr_addr;
                    d.cbe            = `CMD_MEM_WRITE;
                    d.ad_oe          = 1'h1;
                    d.req            = 1'h0;
                    d.gap            = `REQ_GAP;
                end else if (~link.gnt_n & bus_idle) begin
                    d.ad    = '0;
                    d.cbe   = '0;
                    d.ad_oe = 1'h1;
                end
                if (fifo_valid & ~q.req & (q.gap == '0)) begin
                    d.req = 1'h1;
                end
            end
            B_ADDR: begin
                d.st              = B_DATA;
                d.own[`CTL_FRAME] = 1'h0;
                d.own[`CTL_IRDY]  = 1'h1;
                d.ad              = fifo_data;
                d.cbe             = `BE_ALL_N;
                d.wait_cnt        = `DEVSEL_FIRST;
            end
            B_DATA: begin
                if (~link.ctl[`CTL_TRDY]) begin
                    fifo_pop = 1'h1;
                    end_txn  = 1'h1;
                end else if (~link.ctl[`CTL_STOP]) begin
                    end_txn = 1'h1;
                    if (link.ctl[`CTL_DEVSEL]) begin
                        d.tabort = 1'h1;
                        fifo_pop = 1'h1;
                    end
                end else if (link.ctl[`CTL_DEVSEL] & (q.wait_cnt == `DEVSEL_LIMIT)) begin
                    d.mabort = 1'h1;
                    fifo_pop = 1'h1;
                    end_txn  = 1'h1;
                end else if (link.ctl[`CTL_DEVSEL]) begin
                    d.wait_cnt = q.wait_cnt + 3'h1;
                end
            end
            B_TDATA: begin
                if (~link.ctl[`CTL_IRDY]) begin
                    end_txn = 1'h1;
                    if (q.tgt_write) begin
                        d.cfg      = merge_bytes(q.cfg, link.ad, link.cbe);
                        d.chk_data = 1'h1;
                        d.chk_ad   = link.ad;
                        d.chk_cbe  = link.cbe;
                    end
                end
            end
            B_TURN: begin
                d.st = B_IDLE;
            end
        endcase
        if (end_txn) begin
            d.st    = B_TURN;
            d.own   = '0;
            d.ad_oe = 1'h0;
        end
        d.own[`CTL_PERR] = q.chk_data & par_bad;
        d.perr_pulse     = q.chk_data & par_bad;
        d.rel            = q.own & ~d.own;
        d.serr           = (q.chk_addr & par_bad) | peer_perr | ~i_sec_serr_n
                           | q.mabort | q.tabort
                           | (|i_discard_events);
    end

    // all drivers off while reset is low
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==============================================================
    // pins
    assign link.dev_ad      = q.ad;
    assign link.dev_cbe     = q.cbe;
    assign link.dev_ad_oe   = q.ad_oe;
    assign link.dev_par     = q.par;
    assign link.dev_par_oe  = q.par_oe;
    assign link.dev_ctl     = ~q.own;
    assign link.dev_ctl_oe  = q.own | q.rel;
    assign link.dev_serr_oe = q.serr;
    assign link.dev_req_n   = ~q.req;
    assign link.dev_req_oe  = q.live;
    assign o_cfg_value      = q.cfg;
    assign o_master_abort   = q.mabort;
    assign o_target_abort   = q.tabort;
    assign o_parity_error   = q.perr_pulse;
endmodule // bridge_device

`default_nettype wire

//--- verilog/bridge_regs.svh
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH

// ==============================================================
// bus widths
`define AD_W          32
`define CBE_W         4
`define BYTE_W        8
`define CTL_W         6

// ==============================================================
// sustained tri-state control lines, index into the ctl vector
`define CTL_FRAME     0
`define CTL_IRDY      1
`define CTL_TRDY      2
`define CTL_DEVSEL    3
`define CTL_STOP      4
`define CTL_PERR      5

// ==============================================================
// commands and fields
`define CMD_MEM_WRITE 4'h7
`define CMD_CFG_READ  4'hA
`define CMD_CFG_WRITE 4'hB
`define BE_ALL_N      4'h0
`define CFG_TYPE0     2'h0

// ==============================================================
// timing counts in clock cycles, and sizes
`define DEVSEL_FIRST  3'h1
`define DEVSEL_LIMIT  3'h5
`define REQ_GAP       2'h2
`define FIFO_DEPTH    16
`define ERR_EVENTS    4

`endif

//--- verilog/bridge_pkg.sv
`default_nettype none
package bridge_pkg;
`include "bridge_regs.svh"

    // ==============================================================
    // state types
    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_DATA, B_TDATA, B_TURN
    } bridge_state_type;

    typedef enum logic [2:0] {
        H_IDLE, H_ADDR, H_DATA, H_TDATA, H_TURN
    } partner_state_type;

    typedef struct packed {
        bridge_state_type  st;
        logic [2:0]        wait_cnt;
        logic [1:0]        gap;
        logic              req;
        logic              live;
        logic              frame_prev;
        logic [`AD_W-1:0]  ad;
        logic [`CBE_W-1:0] cbe;
        logic              ad_oe;
        logic              par;
        logic              par_oe;
        logic [`CTL_W-1:0] own;
        logic [`CTL_W-1:0] rel;
        logic [`AD_W-1:0]  chk_ad;
        logic [`CBE_W-1:0] chk_cbe;
        logic              chk_data;
        logic              chk_addr;
        logic              tgt_write;
        logic              serr;
        logic [`AD_W-1:0]  cfg;
        logic              mabort;
        logic              tabort;
        logic              perr_pulse;
    } bridge_regs_type;

    typedef struct packed {
        partner_state_type st;
        logic [2:0]        wait_cnt;
        logic              frame_prev;
        logic              gnt;
        logic [`AD_W-1:0]  ad;
        logic [`CBE_W-1:0] cbe;
        logic              ad_oe;
        logic              par;
        logic              par_oe;
        logic              idsel;
        logic [`CTL_W-1:0] own;
        logic [`CTL_W-1:0] rel;
        logic              write;
        logic [`AD_W-1:0]  wdata;
        logic [`AD_W-1:0]  rdata;
        logic              done;
        logic              abort;
        logic [`AD_W-1:0]  rx_data;
        logic              rx_valid;
    } partner_regs_type;

    // ==============================================================
    // helpers
    function automatic logic even_parity(input logic [`AD_W-1:0]  ad,
                                         input logic [`CBE_W-1:0] cbe);
        return ^{ad, cbe};
    endfunction

    function automatic logic [`AD_W-1:0] merge_bytes(input logic [`AD_W-1:0]  old,
                                                     input logic [`AD_W-1:0]  nw,
                                                     input logic [`CBE_W-1:0] be_n);
        logic [`AD_W-1:0] r;
        r = old;
        for (int i = 0; i < `CBE_W; i++) begin
            if (!be_n[i]) begin
                r[i*`BYTE_W +: `BYTE_W] = nw[i*`BYTE_W +: `BYTE_W];
            end
        end
        return r;
    endfunction
endpackage

`default_nettype wire

//--- verilog/pci_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.svh"

interface pci_link_if;
    logic [`AD_W-1:0]  dev_ad;
    logic [`AD_W-1:0]  host_ad;
    logic [`AD_W-1:0]  ad;
    logic [`CBE_W-1:0] dev_cbe;
    logic [`CBE_W-1:0] host_cbe;
    logic [`CBE_W-1:0] cbe;
    logic [`CTL_W-1:0] dev_ctl;
    logic [`CTL_W-1:0] dev_ctl_oe;
    logic [`CTL_W-1:0] host_ctl;
    logic [`CTL_W-1:0] host_ctl_oe;
    logic [`CTL_W-1:0] ctl;
    logic              dev_ad_oe;
    logic              dev_par;
    logic              dev_par_oe;
    logic              dev_serr_oe;
    logic              dev_req_n;
    logic              dev_req_oe;
    logic              host_ad_oe;
    logic              host_par;
    logic              host_par_oe;
    logic              par;
    logic              serr_n;
    logic              req_n;
    logic              gnt_n;
    logic              idsel;

    // pulled-up wires: undriven bits read high
    assign ad     = (dev_ad | {`AD_W{~dev_ad_oe}}) & (host_ad | {`AD_W{~host_ad_oe}});
    assign cbe    = (dev_cbe | {`CBE_W{~dev_ad_oe}}) & (host_cbe | {`CBE_W{~host_ad_oe}});
    assign par    = (dev_par | ~dev_par_oe) & (host_par | ~host_par_oe);
    assign ctl    = (dev_ctl | ~dev_ctl_oe) & (host_ctl | ~host_ctl_oe);
    assign serr_n = ~dev_serr_oe;
    assign req_n  = dev_req_n | ~dev_req_oe;

    modport bridge_end (
        output dev_ad, dev_cbe, dev_ad_oe, dev_par, dev_par_oe, dev_ctl, dev_ctl_oe,
        output dev_serr_oe, dev_req_n, dev_req_oe,
        input  ad, cbe, par, ctl, gnt_n, idsel
    );

    modport partner_end (
        output host_ad, host_cbe, host_ad_oe, host_par, host_par_oe, host_ctl,
        output host_ctl_oe, gnt_n, idsel,
        input  ad, cbe, par, ctl, req_n, serr_n
    );
endinterface // pci_link_if

`default_nettype wire

//--- verilog/bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.svh"

// ==============================================================
// far end: arbiter, config initiator and memory write target
module bus_partner
    import bridge_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    pci_link_if.partner_end        link,
    input  wire logic              i_cfg_valid,
    output logic                   o_cfg_ready,
    input  wire logic              i_cfg_write,
    input  wire logic              i_cfg_idsel,
    input  wire logic [`AD_W-1:0]  i_cfg_addr,
    input  wire logic [`AD_W-1:0]  i_cfg_wdata,
    output logic      [`AD_W-1:0]  o_cfg_rdata,
    output logic                   o_cfg_done,
    output logic                   o_cfg_abort,
    output logic      [`AD_W-1:0]  o_rx_data,
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    output logic                   o_serr
);
    partner_regs_type q;
    partner_regs_type d;
    logic             bus_idle;
    logic             addr_phase;
    logic             end_txn;

    assign bus_idle    = link.ctl[`CTL_FRAME] & link.ctl[`CTL_IRDY];
    assign addr_phase  = ~link.ctl[`CTL_FRAME] & q.frame_prev & (q.st == H_IDLE);
    assign o_cfg_ready = (q.st == H_IDLE) & ~q.gnt & bus_idle;

    // ==============================================================
    // next state
    always_comb begin
        d            = q;
        end_txn      = 1'h0;
        d.frame_prev = link.ctl[`CTL_FRAME];
        d.par        = even_parity(q.ad, q.cbe);
        d.par_oe     = q.ad_oe;
        d.done       = 1'h0;
        d.abort      = 1'h0;
        d.rx_valid   = 1'h0;
        // grant parks on the bridge while the bus is idle
        d.gnt        = (~link.req_n | bus_idle) & ~i_cfg_valid & (q.st == H_IDLE);
        unique case (q.st)
            H_IDLE: begin
                if (addr_phase & (link.cbe == `CMD_MEM_WRITE)) begin
                    d.st               = H_TDATA;
                    d.own[`CTL_DEVSEL] = 1'h1;
                    d.own[`CTL_TRDY]   = i_rx_ready;
                    d.own[`CTL_STOP]   = ~i_rx_ready;
                end else if (i_cfg_valid & o_cfg_ready) begin
                    d.st              = H_ADDR;
                    d.own[`CTL_FRAME] = 1'h1;
                    d.ad              = i_cfg_addr;
                    d.cbe             = i_cfg_write ? `CMD_CFG_WRITE : `CMD_CFG_READ;
                    d.ad_oe           = 1'h1;
                    d.idsel           = i_cfg_idsel;
                    d.write           = i_cfg_write;
                    d.wdata           = i_cfg_wdata;
                end
            end
            H_ADDR: begin
                d.st              = H_DATA;
                d.own[`CTL_FRAME] = 1'h0;
                d.own[`CTL_IRDY]  = 1'h1;
                d.ad              = q.wdata;
                d.ad_oe           = q.write;
                d.cbe             = `BE_ALL_N;
                d.idsel           = 1'h0;
                d.wait_cnt        = `DEVSEL_FIRST;
            end
            H_DATA: begin
                if (~link.ctl[`CTL_TRDY]) begin
                    if (!q.write) begin
                        d.rdata = link.ad;
                    end
                    d.done  = 1'h1;
                    end_txn = 1'h1;
                end else if (~link.ctl[`CTL_STOP]) begin
                    d.abort = 1'h1;
                    end_txn = 1'h1;
                end else if (link.ctl[`CTL_DEVSEL] & (q.wait_cnt == `DEVSEL_LIMIT)) begin
                    d.abort = 1'h1;
                    end_txn = 1'h1;
                end else if (link.ctl[`CTL_DEVSEL]) begin
                    d.wait_cnt = q.wait_cnt + 3'h1;
                end
            end
            H_TDATA: begin
                if (q.own[`CTL_TRDY] & ~link.ctl[`CTL_IRDY]) begin
                    d.rx_data  = link.ad;
                    d.rx_valid = 1'h1;
                    end_txn    = 1'h1;
                end else if (q.own[`CTL_STOP] & link.ctl[`CTL_IRDY]) begin
                    end_txn = 1'h1;
                end
            end
            H_TURN: begin
                d.st = H_IDLE;
            end
        endcase
        if (end_txn) begin
            d.st    = H_TURN;
            d.own   = '0;
            d.ad_oe = 1'h0;
        end
        d.rel = q.own & ~d.own;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==============================================================
    // pins
    assign link.host_ad     = q.ad;
    assign link.host_cbe    = q.cbe;
    assign link.host_ad_oe  = q.ad_oe;
    assign link.host_par    = q.par;
    assign link.host_par_oe = q.par_oe;
    assign link.host_ctl    = ~q.own;
    assign link.host_ctl_oe = q.own | q.rel;
    assign link.gnt_n       = ~q.gnt;
    assign link.idsel       = q.idsel;
    assign o_cfg_rdata      = q.rdata;
    assign o_cfg_done       = q.done;
    assign o_cfg_abort      = q.abort;
    assign o_rx_data        = q.rx_data;
    assign o_rx_valid       = q.rx_valid;
    assign o_serr           = ~link.serr_n;
endmodule // bus_partner

`default_nettype wire

//--- tb/link_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.svh"

module link_props (
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic [`AD_W-1:0]  ad,
    input wire logic [`CBE_W-1:0] cbe,
    input wire logic              par,
    input wire logic [`CTL_W-1:0] ctl,
    input wire logic [`CTL_W-1:0] dev_ctl,
    input wire logic [`CTL_W-1:0] dev_ctl_oe,
    input wire logic              dev_ad_oe,
    input wire logic              dev_par_oe,
    input wire logic              gnt_n,
    input wire logic              req_n,
    input wire logic              idsel
);
    // ==============================================================
    // link checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    req_gap_a: assert property ($rose(req_n) |=> req_n [*2])
        else $error("request gap short");
    release_high_a: assert property ($past(i_reset_n) |->
        (~dev_ctl_oe & $past(dev_ctl_oe) & ~$past(dev_ctl)) == 6'h00) else $error("bad release");
    trdy_hold_a: assert property (!ctl[`CTL_TRDY] && ctl[`CTL_IRDY] |=> !ctl[`CTL_TRDY])
        else $error("trdy dropped");
    grant_start_a: assert property ($rose(dev_ctl_oe[`CTL_FRAME]) |-> !$past(gnt_n))
        else $error("start without grant");
    cmd_phase_a: assert property (dev_ctl_oe[`CTL_FRAME] && $fell(ctl[`CTL_FRAME]) |->
        cbe == `CMD_MEM_WRITE ##1 cbe == `BE_ALL_N) else $error("bad command phase");
    parity_gen_a: assert property (dev_par_oe && $past(dev_ad_oe) |->
        par == ^{$past(ad), $past(cbe)}) else $error("bad parity");
    cfg_claim_a: assert property ($fell(ctl[`CTL_FRAME]) && !dev_ctl_oe[`CTL_FRAME] && idsel
        && cbe[3:1] == 3'h5 && ad[1:0] == 2'h0 |=> !ctl[`CTL_DEVSEL]) else $error("no claim");
    bus_park_a: assert property ((!gnt_n && ctl[`CTL_FRAME] && ctl[`CTL_IRDY]) [*4]
        |-> dev_ad_oe) else $error("bus not parked");

    cover property (!ctl[`CTL_IRDY] && !ctl[`CTL_TRDY] && dev_ctl_oe[`CTL_IRDY]);
    cover property (!ctl[`CTL_TRDY] && dev_ctl_oe[`CTL_TRDY]);
    cover property (dev_ad_oe && ctl[`CTL_FRAME] && ctl[`CTL_IRDY]);
endmodule // link_props

`default_nettype wire

//--- tb/tb_pci_bridge_bus_port_signalling.sv
`timescale 1ns/1ps
`default_nettype none
`include "bridge_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb_pci_bridge_bus_port_signalling;
    logic        i_clk = 0, i_reset_n = 0, wv = 0, cv = 0, cw = 0, cs = 0, rr = 1, sn = 1, t;
    logic        wrdy, crdy, cdone, cab, rxv;
    logic [3:0]  ev = 0;
    logic [31:0] wd = 0, wa = 0, ca = 0, cd = 0, x, cfgv, rdat, rxd, got[$], exp[$];
    int          compares = 0, bad_count = 0, cyc = 0;

    pci_link_if lnk ();
    wire [9:0] oes = {lnk.dev_ad_oe, lnk.dev_par_oe, lnk.dev_ctl_oe, lnk.dev_serr_oe,
        lnk.dev_req_oe};
    bridge_device bridge_device_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(lnk.bridge_end),
        .i_wr_valid(wv), .o_wr_ready(wrdy), .i_wr_data(wd), .i_wr_addr(wa), .i_sec_serr_n(sn),
        .i_discard_events(ev), .o_cfg_value(cfgv), .o_master_abort(), .o_target_abort(),
        .o_parity_error());
    bus_partner bus_partner_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(lnk.partner_end),
        .i_cfg_valid(cv), .o_cfg_ready(crdy), .i_cfg_write(cw), .i_cfg_idsel(cs),
        .i_cfg_addr(ca), .i_cfg_wdata(cd), .o_cfg_rdata(rdat), .o_cfg_done(cdone),
        .o_cfg_abort(cab), .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rr), .o_serr());
    link_props link_props_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .ad(lnk.ad), .cbe(lnk.cbe),
        .par(lnk.par), .ctl(lnk.ctl), .dev_ctl(lnk.dev_ctl), .dev_ctl_oe(lnk.dev_ctl_oe),
        .dev_ad_oe(lnk.dev_ad_oe), .dev_par_oe(lnk.dev_par_oe), .gnt_n(lnk.gnt_n),
        .req_n(lnk.req_n), .idsel(lnk.idsel));

    // ==============================================================
    // clock, watchdog and receive monitor
    always #50 i_clk = ~i_clk;
    always @(negedge i_clk) if (rxv === 1'b1) got.push_back(rxd);
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ==============================================================
    // helpers
    function automatic logic exp_serr(input logic [3:0] e, input logic s);
        return |e || !s;
    endfunction

    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cfg(input logic w, input logic s, input logic [31:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_clk) #1 {cv, cw, cs, ca, cd} = {1'b1, w, s, a, d};
        do @(negedge i_clk); while (crdy !== 1'b1 && ++n < 50);
        @(posedge i_clk) #1 cv = 0;
        do @(negedge i_clk); while (cdone !== 1'b1 && cab !== 1'b1 && ++n < 100);
    endtask

    task automatic err(input logic [3:0] e, input logic s);
        logic seen = 0;
        @(posedge i_clk) #1 {ev, sn} = {e, s};
        @(posedge i_clk) #1 {ev, sn} = 5'h01;
        repeat (4) @(negedge i_clk) seen |= !lnk.serr_n;
        `CHK(seen, exp_serr(e, s))
    endtask

    // ==============================================================
    // main sequence
    initial begin
        void'($urandom(79906));
        repeat (3) @(posedge i_clk);
        `CHK(oes, 10'h000)
        #1 i_reset_n = 1;
        @(posedge i_clk);
        for (int i = 0; i < 6; i++) begin
            x = $urandom;
            cfg(1'b1, 1'b1, x & 32'hFFFFFFFC, x);
            repeat (2) @(negedge i_clk);
            `CHK(cfgv, x)
            cfg(1'b0, 1'b1, 32'h0, 32'h0);
            `CHK(rdat, x)
            cfg(x[0], 1'b0, 32'h0, ~x);
            `CHK(cab, 1'b1)
            `CHK(cfgv, x)
        end
        $display("config test done");
        @(posedge i_clk) #1 {wa, wd, rr, wv} = {x, ~x, 2'b01};
        repeat (24) begin
            @(negedge i_clk) t = wrdy;
            if (t) exp.push_back(wd);
            @(posedge i_clk) #1 if (t) wd = $urandom;
        end
        `CHK(exp.size(), `FIFO_DEPTH)
        @(posedge i_clk) #1 wv = 0;
        repeat (600) @(posedge i_clk) #1 rr = 1'($urandom);
        repeat (60) @(posedge i_clk) #1 rr = 1;
        `CHK(got.size(), exp.size())
        foreach (got[i]) `CHK(got[i], exp[i])
        $display("posted write test done");
        for (int i = 0; i < 6; i++) err(4'h1 << i, i != 5);
        $display("system error test done");
        @(posedge i_clk) #1 i_reset_n = 0;
        #1 `CHK(oes, 10'h000)
        @(posedge i_clk) #1 i_reset_n = 1;
        `CHK(cfgv, 32'h0)
        repeat (8) @(negedge i_clk);
        `CHK({lnk.dev_ad_oe, lnk.ad}, {1'b1, 32'h0})
        $display("reset and park test done");
        report_and_stop();
    end
endmodule // tb_pci_bridge_bus_port_signalling

`default_nettype wire
